// >>> hw/isa_decode_and_register_sets.sv
// instruction decoder with flag word and architectural register arrays
`timescale 1ns/1ps

// ---------------------------------------------------------------
// register array: one write port, two registered read ports
// ---------------------------------------------------------------
module reg_array #(
  parameter int W = 64,
  parameter int N = 32
) (
  input wire logic clk,
  input wire logic wrEn,
  input wire logic [$clog2(N)-1:0] wrIdx,
  input wire logic [W-1:0] wrData,
  input wire logic [$clog2(N)-1:0] rdIdxA,
  input wire logic [$clog2(N)-1:0] rdIdxB,
  output logic [W-1:0] rdA,
  output logic [W-1:0] rdB
);
  logic [W-1:0] mem [N];
  // contents are architectural data, so no reset is spent on them
  always_ff @(posedge clk)
  begin
    if (wrEn)
    begin
      mem[wrIdx] <= wrData;
    end
    rdA <= mem[rdIdxA];
    rdB <= mem[rdIdxB];
  end
endmodule

// ---------------------------------------------------------------
// decoder top
// ---------------------------------------------------------------
module isa_decode_and_register_sets #(
  parameter bit IS64 = 1'b1,
  parameter bit HAS_DSP = 1'b0,
  parameter bit HAS_FP = 1'b1,
  parameter bit HAS_VEC = 1'b1,
  parameter bit HAS_COMPACT = 1'b1,
  parameter bit HAS_PERF = 1'b1,
  parameter bit HAS_DEVCTL = 1'b1,
  parameter bit HAS_HV = 1'b1,
  localparam int GW = (IS64 || HAS_DSP) ? 64 : 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic instrValid,
  input wire logic [31:0] instrWord,
  input wire logic [1:0] fetchAddrLow,
  input wire logic compactMode,
  input wire logic [1:0] privLevel,
  input wire logic [7:0] condWrMask,
  input wire logic [31:0] condWrData,
  input wire logic genWrEn,
  input wire logic [4:0] genWrIdx,
  input wire logic [GW-1:0] genWrData,
  input wire logic fltWrEn,
  input wire logic [4:0] fltWrIdx,
  input wire logic [63:0] fltWrData,
  input wire logic simdWrEn,
  input wire logic [4:0] simdWrIdx,
  input wire logic [127:0] simdWrData,
  output logic decValid,
  output logic len32,
  output logic [5:0] primaryOp,
  output logic [9:0] extOp,
  output logic [15:0] immField,
  output logic [4:0] dstReg,
  output logic [4:0] srcRegA,
  output logic [4:0] srcRegB,
  output logic recordForm,
  output logic [2:0] condField,
  output logic condBit,
  output logic [31:0] condFlags,
  output logic [2:0] moveKind,
  output logic moveToDir,
  output logic [9:0] spaceIdx,
  output logic privFault,
  output logic hvFault,
  output logic illegal,
  output logic alignFault,
  output logic [GW-1:0] genRdA,
  output logic [GW-1:0] genRdB,
  output logic [63:0] fltRdA,
  output logic [63:0] fltRdB,
  output logic [127:0] simdRdA,
  output logic [127:0] simdRdB
);
  logic decValid_ff, len32_ff, recordForm_ff, condBit_ff, moveToDir_ff;
  logic privFault_ff, hvFault_ff, illegal_ff, alignFault_ff;
  logic [5:0] primaryOp_ff;
  logic [9:0] extOp_ff, spaceIdx_ff;
  logic [15:0] immField_ff;
  logic [4:0] dstReg_ff, srcRegA_ff, srcRegB_ff;
  logic [2:0] condField_ff;
  logic [31:0] condFlags_ff;
  isa_decode_pkg::move_e moveKind_ff;

  logic nxt_decValid, nxt_len32, nxt_recordForm, nxt_condBit, nxt_moveToDir;
  logic nxt_privFault, nxt_hvFault, nxt_illegal, nxt_alignFault;
  logic [5:0] nxt_primaryOp;
  logic [9:0] nxt_extOp, nxt_spaceIdx;
  logic [15:0] nxt_immField;
  logic [4:0] nxt_dstReg, nxt_srcRegA, nxt_srcRegB;
  logic [2:0] nxt_condField;
  logic [31:0] nxt_condFlags;
  isa_decode_pkg::move_e nxt_moveKind;

  logic inCompact, isStdGroup, needPriv, needHv, catMissing;
  logic [5:0] opc;
  logic [9:0] xo;

  // map a four-bit compact field onto registers 0-7 and 24-31
  function automatic logic [4:0] subsetReg(input logic [3:0] f);
    subsetReg = f[3] ? {2'h3, f[2:0]} : {2'h0, f[2:0]};
  endfunction

  // ---------------------------------------------------------------
  // instruction decode
  // ---------------------------------------------------------------
  always_comb
  begin
    opc = instrWord[isa_decode_pkg::OPC_HI:isa_decode_pkg::OPC_LO];
    xo = instrWord[isa_decode_pkg::XO_HI:isa_decode_pkg::XO_LO];
    // a core without the compact set ignores the mode bit
    inCompact = HAS_COMPACT && compactMode;
    isStdGroup = (opc == isa_decode_pkg::OP_VEC) || (opc == isa_decode_pkg::OP_EXT);
    nxt_decValid = instrValid;
    nxt_primaryOp = opc;
    nxt_extOp = xo;
    nxt_immField = instrWord[isa_decode_pkg::IMM_HI:isa_decode_pkg::IMM_LO];
    nxt_dstReg = instrWord[isa_decode_pkg::RT_HI:isa_decode_pkg::RT_LO];
    nxt_srcRegA = instrWord[isa_decode_pkg::RA_HI:isa_decode_pkg::RA_LO];
    nxt_srcRegB = instrWord[isa_decode_pkg::RB_HI:isa_decode_pkg::RB_LO];
    nxt_recordForm = instrWord[isa_decode_pkg::RC_BIT];
    nxt_condField = instrWord[isa_decode_pkg::BF_HI:isa_decode_pkg::BF_LO];
    nxt_len32 = 1'b1;
    if (inCompact && !isStdGroup)
    begin
      if (instrWord[isa_decode_pkg::C32_FLAG])
      begin
        // long compact form: target doubles as first source
        nxt_srcRegA = instrWord[isa_decode_pkg::RT_HI:isa_decode_pkg::RT_LO];
        nxt_srcRegB = instrWord[isa_decode_pkg::RA_HI:isa_decode_pkg::RA_LO];
      end
      else
      begin
        // short form lives in the upper halfword only
        nxt_len32 = 1'b0;
        nxt_primaryOp = {2'h0, instrWord[isa_decode_pkg::C16_OP_HI:isa_decode_pkg::C16_OP_LO]};
        nxt_extOp = 10'h000;
        nxt_immField = {12'h000, instrWord[isa_decode_pkg::C16_IMM_HI:isa_decode_pkg::C16_IMM_LO]};
        nxt_dstReg = subsetReg(instrWord[isa_decode_pkg::C16_RX_HI:isa_decode_pkg::C16_RX_LO]);
        nxt_srcRegA = nxt_dstReg;
        nxt_srcRegB = subsetReg(instrWord[isa_decode_pkg::C16_RY_HI:isa_decode_pkg::C16_RY_LO]);
        nxt_recordForm = 1'b0;
        nxt_condField = 3'h0;
      end
    end
    // halfword targets only legal while compact decode is live
    nxt_alignFault = instrValid && (fetchAddrLow[0] || (!inCompact && fetchAddrLow[1]));
  end

  // ---------------------------------------------------------------
  // dedicated move instructions and privilege checks
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_moveKind = isa_decode_pkg::MV_NONE;
    nxt_moveToDir = 1'b0;
    // the two five-bit halves of the entry number are stored swapped
    nxt_spaceIdx = {instrWord[isa_decode_pkg::RB_HI:isa_decode_pkg::RB_LO],
                    instrWord[isa_decode_pkg::RA_HI:isa_decode_pkg::RA_LO]};
    needPriv = 1'b0;
    needHv = 1'b0;
    catMissing = 1'b0;
    if (nxt_len32 && opc == isa_decode_pkg::OP_EXT)
    begin
      if (xo == isa_decode_pkg::XO_FROM_SPECIAL || xo == isa_decode_pkg::XO_TO_SPECIAL)
      begin
        nxt_moveKind = isa_decode_pkg::MV_SPR;
        nxt_moveToDir = (xo == isa_decode_pkg::XO_TO_SPECIAL);
        needPriv = nxt_spaceIdx[isa_decode_pkg::SPR_PRIV_BIT];
        needHv = (nxt_spaceIdx[9:8] == isa_decode_pkg::SPR_HV_TAG);
      end
      else if (xo == isa_decode_pkg::XO_FROM_PERF || xo == isa_decode_pkg::XO_TO_PERF)
      begin
        nxt_moveKind = isa_decode_pkg::MV_PMR;
        nxt_moveToDir = (xo == isa_decode_pkg::XO_TO_PERF);
        // control writes are privileged, some counters stay user readable
        needPriv = nxt_moveToDir || nxt_spaceIdx[isa_decode_pkg::PMR_USER_RD_BIT];
        catMissing = !HAS_PERF;
      end
      else if (xo == isa_decode_pkg::XO_FROM_DEVCTL || xo == isa_decode_pkg::XO_TO_DEVCTL)
      begin
        // entries live outside the core; only the index is handed out
        nxt_moveKind = isa_decode_pkg::MV_DCR;
        nxt_moveToDir = (xo == isa_decode_pkg::XO_TO_DEVCTL);
        needPriv = 1'b1;
        needHv = 1'b1;
        catMissing = !HAS_DEVCTL;
      end
      else if (xo == isa_decode_pkg::XO_MFMSR || xo == isa_decode_pkg::XO_MTMSR)
      begin
        nxt_moveKind = isa_decode_pkg::MV_STATE;
        nxt_moveToDir = (xo == isa_decode_pkg::XO_MTMSR);
        needPriv = 1'b1;
      end
    end
    if (nxt_len32 && (opc == isa_decode_pkg::OP_FP_S || opc == isa_decode_pkg::OP_FP_D))
    begin
      catMissing = !HAS_FP;
    end
    if (nxt_len32 && opc == isa_decode_pkg::OP_VEC)
    begin
      catMissing = !(HAS_VEC || HAS_DSP);
    end
    nxt_illegal = instrValid && catMissing;
    nxt_privFault = instrValid && !catMissing && needPriv
                    && (privLevel == isa_decode_pkg::PRIV_USER);
    // without a hypervisor the supervisor owns everything
    nxt_hvFault = instrValid && !catMissing && needHv && HAS_HV
                  && (privLevel == isa_decode_pkg::PRIV_GUEST);
  end

  // ---------------------------------------------------------------
  // branch condition flags
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_condFlags = condFlags_ff;
    // field 0 sits in the top nibble
    for (int i = 0; i < isa_decode_pkg::FLAG_FIELDS; i++)
    begin
      if (condWrMask[i])
      begin
        nxt_condFlags[31-i*4 -: 4] = condWrData[31-i*4 -: 4];
      end
    end
    // bit picked by the BI field, for branches and the select op
    nxt_condBit = condFlags_ff[5'd31 - instrWord[isa_decode_pkg::RA_HI:isa_decode_pkg::RA_LO]];
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      decValid_ff <= 1'b0;
      len32_ff <= 1'b1;
      primaryOp_ff <= 6'h00;
      extOp_ff <= 10'h000;
      immField_ff <= 16'h0000;
      dstReg_ff <= 5'h00;
      srcRegA_ff <= 5'h00;
      srcRegB_ff <= 5'h00;
      recordForm_ff <= 1'b0;
      condField_ff <= 3'h0;
      condBit_ff <= 1'b0;
      condFlags_ff <= isa_decode_pkg::FLAGS_RESET;
      moveKind_ff <= isa_decode_pkg::MV_NONE;
      moveToDir_ff <= 1'b0;
      spaceIdx_ff <= 10'h000;
      privFault_ff <= 1'b0;
      hvFault_ff <= 1'b0;
      illegal_ff <= 1'b0;
      alignFault_ff <= 1'b0;
    end
    else
    begin
      decValid_ff <= nxt_decValid;
      len32_ff <= nxt_len32;
      primaryOp_ff <= nxt_primaryOp;
      extOp_ff <= nxt_extOp;
      immField_ff <= nxt_immField;
      dstReg_ff <= nxt_dstReg;
      srcRegA_ff <= nxt_srcRegA;
      srcRegB_ff <= nxt_srcRegB;
      recordForm_ff <= nxt_recordForm;
      condField_ff <= nxt_condField;
      condBit_ff <= nxt_condBit;
      condFlags_ff <= nxt_condFlags;
      moveKind_ff <= nxt_moveKind;
      moveToDir_ff <= nxt_moveToDir;
      spaceIdx_ff <= nxt_spaceIdx;
      privFault_ff <= nxt_privFault;
      hvFault_ff <= nxt_hvFault;
      illegal_ff <= nxt_illegal;
      alignFault_ff <= nxt_alignFault;
    end
  end

  // output wiring
  assign decValid = decValid_ff;
  assign len32 = len32_ff;
  assign primaryOp = primaryOp_ff;
  assign extOp = extOp_ff;
  assign immField = immField_ff;
  assign dstReg = dstReg_ff;
  assign srcRegA = srcRegA_ff;
  assign srcRegB = srcRegB_ff;
  assign recordForm = recordForm_ff;
  assign condField = condField_ff;
  assign condBit = condBit_ff;
  assign condFlags = condFlags_ff;
  assign moveKind = moveKind_ff;
  assign moveToDir = moveToDir_ff;
  assign spaceIdx = spaceIdx_ff;
  assign privFault = privFault_ff;
  assign hvFault = hvFault_ff;
  assign illegal = illegal_ff;
  assign alignFault = alignFault_ff;

  // ---------------------------------------------------------------
  // register arrays, read by the operands being decoded
  // ---------------------------------------------------------------
  reg_array #(.W(GW), .N(isa_decode_pkg::REG_COUNT)) genRegs (
    .clk(clk), .wrEn(genWrEn), .wrIdx(genWrIdx), .wrData(genWrData),
    .rdIdxA(nxt_srcRegA), .rdIdxB(nxt_srcRegB), .rdA(genRdA), .rdB(genRdB)
  );
  generate
    if (HAS_FP)
    begin : gFlt
      reg_array #(.W(64), .N(isa_decode_pkg::REG_COUNT)) fltRegs (
        .clk(clk), .wrEn(fltWrEn), .wrIdx(fltWrIdx), .wrData(fltWrData),
        .rdIdxA(nxt_srcRegA), .rdIdxB(nxt_srcRegB), .rdA(fltRdA), .rdB(fltRdB)
      );
    end
    else
    begin : gNoFlt
      assign fltRdA = 64'h0;
      assign fltRdB = 64'h0;
    end
    if (HAS_VEC)
    begin : gSimd
      reg_array #(.W(128), .N(isa_decode_pkg::REG_COUNT)) simdRegs (
        .clk(clk), .wrEn(simdWrEn), .wrIdx(simdWrIdx), .wrData(simdWrData),
        .rdIdxA(nxt_srcRegA), .rdIdxB(nxt_srcRegB), .rdA(simdRdA), .rdB(simdRdB)
      );
    end
    else
    begin : gNoSimd
      assign simdRdA = 128'h0;
      assign simdRdB = 128'h0;
    end
  endgenerate
endmodule

// >>> hw/isa_decode_pkg.sv
// shared constants for the instruction decoder and its register sets
// ---------------------------------------------------------------
// ---------------------------------------------------------------
package isa_decode_pkg;
  localparam int WORD_W = 32;
  localparam int OPC_HI = 31;
  localparam int OPC_LO = 26;
  localparam int XO_HI = 10;
  localparam int XO_LO = 1;
  localparam int IMM_HI = 15;
  localparam int IMM_LO = 0;
  localparam int RT_HI = 25;
  localparam int RT_LO = 21;
  localparam int RA_HI = 20;
  localparam int RA_LO = 16;
  localparam int RB_HI = 15;
  localparam int RB_LO = 11;
  localparam int BF_HI = 25;
  localparam int BF_LO = 23;
  localparam int RC_BIT = 0;
  localparam int HALF_LO = 16;
  localparam int C16_OP_HI = 31;
  localparam int C16_OP_LO = 28;
  localparam int C16_RX_HI = 27;
  localparam int C16_RX_LO = 24;
  localparam int C16_RY_HI = 23;
  localparam int C16_RY_LO = 20;
  localparam int C16_IMM_HI = 19;
  localparam int C16_IMM_LO = 16;
  localparam int C32_FLAG = 31;
  localparam int REG_COUNT = 32;
  localparam int SPACE_ENTRIES = 1024;
  localparam int FLAG_FIELDS = 8;
  localparam int FLAG_NIB = 4;
  localparam int SPR_PRIV_BIT = 9;
  localparam int PMR_USER_RD_BIT = 7;
  localparam logic [1:0] SPR_HV_TAG = 2'h3;
  localparam logic [5:0] OP_VEC = 6'h04;
  localparam logic [5:0] OP_EXT = 6'h1F;
  localparam logic [5:0] OP_FP_S = 6'h3B;
  localparam logic [5:0] OP_FP_D = 6'h3F;
  localparam logic [9:0] XO_FROM_SPECIAL = 10'h153;
  localparam logic [9:0] XO_TO_SPECIAL = 10'h1D3;
  localparam logic [9:0] XO_FROM_PERF = 10'h14E;
  localparam logic [9:0] XO_TO_PERF = 10'h1CE;
  localparam logic [9:0] XO_FROM_DEVCTL = 10'h143;
  localparam logic [9:0] XO_TO_DEVCTL = 10'h1C3;
  localparam logic [9:0] XO_MFMSR = 10'h053;
  localparam logic [9:0] XO_MTMSR = 10'h092;
  localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;
  typedef enum logic [1:0] {PRIV_USER = 2'h0, PRIV_GUEST = 2'h1, PRIV_HYP = 2'h3} priv_e;
  typedef enum logic [2:0] {
    MV_NONE = 3'h0, MV_SPR = 3'h1, MV_PMR = 3'h3, MV_DCR = 3'h2, MV_STATE = 3'h6
  } move_e;
endpackage

// >>> testbench/fetch_model.sv
// behavioural fetch stage feeding instruction words
`timescale 1ns/1ps

module fetch_model (
  input wire logic clk,
  output logic instrValid,
  output logic [31:0] instrWord,
  output logic [1:0] fetchAddrLow
);
  // idle at time zero
  initial
  begin
    instrValid = 1'b0;
    instrWord = 32'h0000_0000;
    fetchAddrLow = 2'h0;
  end

  // one whole 32-bit word per call; halfword addresses allowed
  // stale lines are inverted so a decoder cannot lean on held values
  task automatic send(input logic [31:0] w, input logic [1:0] a);
    @(negedge clk);
    instrValid = 1'b1;
    instrWord = w;
    fetchAddrLow = a;
    @(negedge clk);
    instrValid = 1'b0;
    instrWord = ~w;
    fetchAddrLow = ~a;
  endtask
endmodule

// >>> testbench/isa_decode_chk.sv
// assertion checker bound to the decoder top
`timescale 1ns/1ps

// ---------------------------------------------------------------
// port-level checks
// ---------------------------------------------------------------
module isa_decode_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic instrValid,
  input wire logic [31:0] instrWord,
  input wire logic [1:0] fetchAddrLow,
  input wire logic compactMode,
  input wire logic [1:0] privLevel,
  input wire logic [7:0] condWrMask,
  input wire logic [31:0] condWrData,
  input wire logic decValid,
  input wire logic len32,
  input wire logic [5:0] primaryOp,
  input wire logic [9:0] extOp,
  input wire logic [15:0] immField,
  input wire logic [4:0] dstReg,
  input wire logic [4:0] srcRegA,
  input wire logic [4:0] srcRegB,
  input wire logic [31:0] condFlags,
  input wire logic [2:0] moveKind,
  input wire logic privFault,
  input wire logic hvFault,
  input wire logic alignFault
);
  logic [5:0] opc;
  logic [9:0] xo;
  logic grp;
  logic shortForm;
  logic msrUser;
  logic devGuest;

  // word classification; short words are compact, top bit clear, not a shared group
  assign opc = instrWord[31:26];
  assign xo = instrWord[10:1];
  assign grp = (opc == isa_decode_pkg::OP_VEC) || (opc == isa_decode_pkg::OP_EXT);
  assign shortForm = compactMode && !instrWord[31] && !grp;
  assign msrUser = instrValid && privLevel == 2'h0 && opc == isa_decode_pkg::OP_EXT
    && xo == isa_decode_pkg::XO_MFMSR;
  assign devGuest = instrValid && privLevel == 2'h1 && opc == isa_decode_pkg::OP_EXT
    && (xo == isa_decode_pkg::XO_FROM_DEVCTL || xo == isa_decode_pkg::XO_TO_DEVCTL);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_valid_follows: assert property (instrValid |=> decValid)
    else $error("decode valid missing");
  a_opcode_top_six: assert property (!shortForm |=> len32 && primaryOp == $past(opc))
    else $error("primary opcode wrong");
  a_ext_imm_fields: assert property (!shortForm |=>
    extOp == $past(instrWord[10:1]) && immField == $past(instrWord[15:0]))
    else $error("secondary or immediate field wrong");
  a_triadic_regs: assert property (!compactMode |=>
    {dstReg, srcRegA, srcRegB} == $past(instrWord[25:11]))
    else $error("register operands wrong");
  a_compact_short: assert property (shortForm |=> !len32 && extOp == 10'h000
    && primaryOp == {2'h0, $past(instrWord[31:28])})
    else $error("short compact decode wrong");
  a_short_dyadic: assert property (shortForm |=> dstReg == srcRegA
    && srcRegA[4:3] != 2'h1 && srcRegA[4:3] != 2'h2)
    else $error("short operand mapping wrong");
  a_compact_groups: assert property (compactMode && grp |=>
    len32 && extOp == $past(xo))
    else $error("shared group not standard");
  a_flag_hold: assert property (condWrMask == 8'h00 |=> $stable(condFlags))
    else $error("flag word changed unasked");
  a_flag_field0: assert property (condWrMask[0] |=>
    condFlags[31:28] == $past(condWrData[31:28]))
    else $error("flag field zero not written");
  a_align_fault: assert property (instrValid && compactMode && fetchAddrLow[0] |=> alignFault)
    else $error("odd compact fetch accepted");
  a_msr_user: assert property (msrUser |=> privFault && moveKind == isa_decode_pkg::MV_STATE)
    else $error("user machine state move not faulted");
  a_dev_guest: assert property (devGuest |=>
    hvFault && !privFault && moveKind == isa_decode_pkg::MV_DCR)
    else $error("guest device move not trapped");

  // main scenarios reached
  c_short: cover property (shortForm ##1 decValid);
  c_msr: cover property (msrUser);
  c_dev: cover property (devGuest);
endmodule

bind isa_decode_and_register_sets isa_decode_chk chk (.clk(clk), .rst(rst),
  .instrValid(instrValid), .instrWord(instrWord), .fetchAddrLow(fetchAddrLow),
  .compactMode(compactMode), .privLevel(privLevel), .condWrMask(condWrMask),
  .condWrData(condWrData), .decValid(decValid), .len32(len32), .primaryOp(primaryOp),
  .extOp(extOp), .immField(immField), .dstReg(dstReg), .srcRegA(srcRegA),
  .srcRegB(srcRegB), .condFlags(condFlags), .moveKind(moveKind),
  .privFault(privFault), .hvFault(hvFault), .alignFault(alignFault));

// >>> testbench/tb_isa_decode_and_register_sets.sv
// self-checking bench for the instruction decoder
`timescale 1ns/1ps

module tb_isa_decode_and_register_sets;
  logic clk = 1'b0, rst = 1'b1, compactMode = 1'b0, genWrEn = 1'b0, fltWrEn = 1'b0;
  logic simdWrEn = 1'b0;
  logic [1:0] privLevel = 2'h3;
  logic [7:0] condWrMask = 8'h00;
  logic [31:0] condWrData = 32'h0000_0000;
  logic [4:0] genWrIdx = 5'h00, fltWrIdx = 5'h00, simdWrIdx = 5'h00;
  logic [63:0] genWrData = 64'h0, fltWrData = 64'h0;
  logic [127:0] simdWrData = 128'h0;
  logic instrValid, len32, decValid, recordForm, condBit, moveToDir;
  logic privFault, hvFault, illegal, alignFault;
  logic [31:0] instrWord, condFlags;
  logic [1:0] fetchAddrLow;
  logic [5:0] primaryOp;
  logic [9:0] extOp, spaceIdx;
  logic [15:0] immField;
  logic [4:0] dstReg, srcRegA, srcRegB;
  logic [2:0] condField, moveKind;
  logic [63:0] genRdA, genRdB, fltRdA, fltRdB;
  logic [127:0] simdRdA, simdRdB;
  logic [31:0] words [3] = '{32'h7C64_2A15, 32'h3860_FFFF, 32'hFC00_0C01};
  int err_total = 0;
  int checks_done = 0;

  always #2 clk = ~clk;

  fetch_model fm (.clk(clk), .instrValid(instrValid), .instrWord(instrWord),
    .fetchAddrLow(fetchAddrLow));

  isa_decode_and_register_sets uut (.clk(clk), .rst(rst), .instrValid(instrValid),
    .instrWord(instrWord), .fetchAddrLow(fetchAddrLow), .compactMode(compactMode),
    .privLevel(privLevel), .condWrMask(condWrMask), .condWrData(condWrData),
    .genWrEn(genWrEn), .genWrIdx(genWrIdx), .genWrData(genWrData), .fltWrEn(fltWrEn),
    .fltWrIdx(fltWrIdx), .fltWrData(fltWrData), .simdWrEn(simdWrEn),
    .simdWrIdx(simdWrIdx), .simdWrData(simdWrData), .decValid(decValid), .len32(len32),
    .primaryOp(primaryOp), .extOp(extOp), .immField(immField), .dstReg(dstReg),
    .srcRegA(srcRegA), .srcRegB(srcRegB), .recordForm(recordForm),
    .condField(condField), .condBit(condBit), .condFlags(condFlags),
    .moveKind(moveKind), .moveToDir(moveToDir), .spaceIdx(spaceIdx),
    .privFault(privFault), .hvFault(hvFault), .illegal(illegal),
    .alignFault(alignFault), .genRdA(genRdA), .genRdB(genRdB), .fltRdA(fltRdA),
    .fltRdB(fltRdB), .simdRdA(simdRdA), .simdRdB(simdRdB));

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    if (err_total == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // standard words: fields by fixed position, bit 31 of the word is the msb
  task automatic t_standard();
    foreach (words[i])
    begin
      fm.send(words[i], 2'h0);
      chk(decValid, 1'b1);
      chk(primaryOp, words[i][31:26]);
      chk(extOp, words[i][10:1]);
      chk(immField, words[i][15:0]);
      chk({dstReg, srcRegA, srcRegB}, words[i][25:11]);
      chk({len32, recordForm, illegal}, {1'b1, words[i][0], 1'b0});
    end
  endtask

  // compact mode: short form, shared groups, halfword alignment
  task automatic t_compact();
    compactMode = 1'b1;
    fm.send(32'h2A53_0000, 2'h2);
    chk({len32, primaryOp, extOp}, {1'b0, 6'h02, 10'h000});
    chk({dstReg, srcRegA, srcRegB}, {5'h1A, 5'h1A, 5'h05});
    chk({immField, alignFault}, {16'h0003, 1'b0});
    fm.send(32'h7C64_2A15, 2'h0);
    chk({len32, primaryOp, extOp}, {1'b1, 6'h1F, 10'h10A});
    fm.send(32'h1000_0000, 2'h1);
    chk({len32, primaryOp, alignFault}, {1'b1, 6'h04, 1'b1});
    fm.send(32'h8000_0000, 2'h0);
    chk(len32, 1'b1);
    compactMode = 1'b0;
    fm.send(32'h7C64_2A15, 2'h2);
    chk(alignFault, 1'b1);
  endtask

  task automatic mv(input logic [9:0] xo, input logic [9:0] idx, input logic [1:0] pl,
    input logic [2:0] kind, input logic [2:0] flags);
    privLevel = pl;
    fm.send({isa_decode_pkg::OP_EXT, 5'h03, idx[4:0], idx[9:5], xo, 1'b0}, 2'h0);
    chk({moveKind, spaceIdx}, {kind, idx});
    chk({moveToDir, privFault, hvFault}, flags);
  endtask

  // move instructions across every space, using the user, guest and hypervisor levels
  task automatic t_moves();
    mv(isa_decode_pkg::XO_FROM_SPECIAL, 10'h008, 2'h0, 3'h1, 3'b000);
    mv(isa_decode_pkg::XO_FROM_SPECIAL, 10'h200, 2'h0, 3'h1, 3'b010);
    mv(isa_decode_pkg::XO_TO_SPECIAL, 10'h300, 2'h1, 3'h1, 3'b101);
    mv(isa_decode_pkg::XO_TO_SPECIAL, 10'h300, 2'h3, 3'h1, 3'b100);
    mv(isa_decode_pkg::XO_FROM_PERF, 10'h010, 2'h0, 3'h3, 3'b000);
    mv(isa_decode_pkg::XO_FROM_PERF, 10'h080, 2'h0, 3'h3, 3'b010);
    mv(isa_decode_pkg::XO_TO_PERF, 10'h010, 2'h0, 3'h3, 3'b110);
    mv(isa_decode_pkg::XO_TO_PERF, 10'h010, 2'h1, 3'h3, 3'b100);
    mv(isa_decode_pkg::XO_FROM_DEVCTL, 10'h005, 2'h1, 3'h2, 3'b001);
    mv(isa_decode_pkg::XO_TO_DEVCTL, 10'h005, 2'h0, 3'h2, 3'b110);
    mv(isa_decode_pkg::XO_MFMSR, 10'h000, 2'h0, 3'h6, 3'b010);
    mv(isa_decode_pkg::XO_MTMSR, 10'h000, 2'h1, 3'h6, 3'b100);
    privLevel = 2'h3;
  endtask

  // per-field flag writes, then branch bit and field selection
  task automatic t_flags();
    chk(condFlags, isa_decode_pkg::FLAGS_RESET);
    @(negedge clk);
    condWrMask = 8'h01;
    condWrData = 32'hA5A5_A5A5;
    @(negedge clk);
    condWrMask = 8'h80;
    condWrData = 32'h0000_000F;
    @(negedge clk);
    condWrMask = 8'h00;
    chk(condFlags, 32'hA000_000F);
    fm.send({6'h10, 3'h5, 23'h0}, 2'h0);
    chk({condField, condBit}, {3'h5, 1'b1});
    fm.send({6'h10, 5'h00, 5'h1F, 16'h0}, 2'h0);
    chk(condBit, 1'b1);
    fm.send({6'h10, 5'h00, 5'h01, 16'h0}, 2'h0);
    chk(condBit, 1'b0);
  endtask

  // write each array, then read back through decoded sources
  task automatic t_arrays();
    @(negedge clk);
    {genWrEn, fltWrEn, simdWrEn} = 3'b111;
    {genWrIdx, fltWrIdx, simdWrIdx} = {5'h05, 5'h05, 5'h09};
    genWrData = 64'h0123_4567_89AB_CDEF;
    fltWrData = 64'hFEDC_BA98_7654_3210;
    simdWrData = {2{64'h0F0F_1234_5678_A5A5}};
    @(negedge clk);
    {genWrEn, fltWrEn, simdWrEn} = 3'b000;
    fm.send({6'h1F, 5'h00, 5'h05, 5'h09, 11'h000}, 2'h0);
    chk(genRdA, 64'h0123_4567_89AB_CDEF);
    chk(fltRdA, 64'hFEDC_BA98_7654_3210);
    chk(simdRdB, {2{64'h0F0F_1234_5678_A5A5}});
    // swap the sources so the other read port of each array is seen
    fm.send({6'h1F, 5'h00, 5'h09, 5'h05, 11'h000}, 2'h0);
    chk(genRdB, 64'h0123_4567_89AB_CDEF);
    chk(fltRdB, 64'hFEDC_BA98_7654_3210);
    chk(simdRdA, {2{64'h0F0F_1234_5678_A5A5}});
  endtask

  // hang guard: the whole run needs about 60 cycles
  initial
  begin
    repeat (3000) @(posedge clk);
    err_total++;
    final_report();
  end

  // main sequence
  initial
  begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    chk({decValid, len32, alignFault}, {1'b0, 1'b1, 1'b0});
    t_standard();
    t_compact();
    t_moves();
    t_flags();
    t_arrays();
    final_report();
  end
endmodule
